// *** core/pld_led_control.sv ***
// LED driver control: polarity sensing, duplex strap, LED functions.
// Assumes the register port is driven by the management interface.
`timescale 1ns/1ps
`default_nettype none

module pld_led_control #(
  parameter int unsigned CNT_W      = 24,
  parameter int unsigned NORMAL_CYC = pld_pkg::NORMAL_STRETCH_CYC,
  parameter int unsigned MEDIUM_CYC = pld_pkg::MEDIUM_STRETCH_CYC,
  parameter int unsigned LONG_CYC   = pld_pkg::LONG_STRETCH_CYC,
  parameter int unsigned FAST_CYC   = pld_pkg::BLINK_FAST_CYC,
  parameter int unsigned SLOW_CYC   = pld_pkg::BLINK_SLOW_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Management register port
  input  wire logic        regWrEn,
  input  wire logic [15:0] regWrData,
  output logic      [15:0] regRdData,
  // PHY status
  input  wire logic        linkUp,
  input  wire logic        duplexFull,
  input  wire logic        txActive,
  input  wire logic        rxActive,
  input  wire logic        colActive,
  // LED pins
  input  wire logic        firstLedPinIn,
  output logic             firstLedPinOut,
  output logic             firstLedPinOeN,
  input  wire logic        secondLedPinIn,
  output logic             secondLedPinOut,
  output logic             secondLedPinOeN,
  // Reset strap result
  output logic             duplexSelectBit
);
  import pld_pkg::*;

  if (CNT_W > 31 || NORMAL_CYC == 0 || MEDIUM_CYC == 0 || LONG_CYC == 0 ||
      FAST_CYC == 0 || SLOW_CYC == 0 || LONG_CYC >= (1 << CNT_W) ||
      MEDIUM_CYC >= (1 << CNT_W) || NORMAL_CYC >= (1 << CNT_W) ||
      FAST_CYC >= (1 << CNT_W) || SLOW_CYC >= (1 << CNT_W)) begin : g_check
    $error("pld_led_control: counts do not fit CNT_W");
  end

  function automatic logic [CNT_W-1:0] stretchLen(input logic [1:0] code);
    case (code)
      STRETCH_MEDIUM: stretchLen = CNT_W'(MEDIUM_CYC);
      STRETCH_LONG:   stretchLen = CNT_W'(LONG_CYC);
      // Reserved code falls back to normal
      default:        stretchLen = CNT_W'(NORMAL_CYC);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] countDown(input logic [CNT_W-1:0] cnt,
                                                  input int unsigned      len);
    countDown = (cnt == '0) ? CNT_W'(len - 1) : cnt - 1'b1;
  endfunction

  pld_state_e       state_reg, state_next;
  logic             polA_reg, polA_next;
  logic             polB_reg, polB_next;
  logic             duplex_reg, duplex_next;
  logic [15:0]      ledCtrl_reg, ledCtrl_next;
  logic [1:0]       pinOut_reg, pinOut_next;
  logic             oeN_reg, oeN_next;
  logic [CNT_W-1:0] fastCnt_reg, fastCnt_next;
  logic [CNT_W-1:0] slowCnt_reg, slowCnt_next;
  logic             fastPh_reg, fastPh_next;
  logic             slowPh_reg, slowPh_next;
  logic [3:0]       firstSel;
  logic [3:0]       secondSel;
  logic             strchEn;

  pld_led_if #(.CNT_W(CNT_W)) first_led_pin ();
  pld_led_if #(.CNT_W(CNT_W)) second_led_pin ();

  assign firstSel  = ledCtrl_reg[FIRST_FN_LSB +: 4];
  assign secondSel = ledCtrl_reg[SECOND_FN_LSB +: 4];
  assign strchEn   = ledCtrl_reg[STRETCH_EN_BIT];

  always_comb begin
    first_led_pin.sel           = firstSel;
    second_led_pin.sel           = secondSel;
    first_led_pin.stretchCycles = stretchLen(ledCtrl_reg[STRETCH_SEL_LSB +: 2]);
    second_led_pin.stretchCycles = first_led_pin.stretchCycles;
    first_led_pin.stretchEn     = strchEn;
    second_led_pin.stretchEn     = strchEn;
    first_led_pin.txAct         = txActive;
    second_led_pin.txAct         = txActive;
    first_led_pin.rxAct         = rxActive;
    second_led_pin.rxAct         = rxActive;
    first_led_pin.colAct        = colActive;
    second_led_pin.colAct        = colActive;
    first_led_pin.link          = linkUp;
    second_led_pin.link          = linkUp;
    first_led_pin.duplex        = duplexFull;
    second_led_pin.duplex        = duplexFull;
    first_led_pin.blinkFast     = fastPh_reg;
    second_led_pin.blinkFast     = fastPh_reg;
    first_led_pin.blinkSlow     = slowPh_reg;
    second_led_pin.blinkSlow     = slowPh_reg;
  end

  pld_led_func #(.CNT_W(CNT_W)) u_funcA (.clk(clk), .rst(rst), .ce(ce), .io(first_led_pin));
  pld_led_func #(.CNT_W(CNT_W)) u_funcB (.clk(clk), .rst(rst), .ce(ce), .io(second_led_pin));

  // Blink phase generators
  always_comb begin
    fastCnt_next = fastCnt_reg;
    slowCnt_next = slowCnt_reg;
    fastPh_next  = fastPh_reg;
    slowPh_next  = slowPh_reg;
    if (ce) begin
      fastCnt_next = countDown(fastCnt_reg, FAST_CYC);
      slowCnt_next = countDown(slowCnt_reg, SLOW_CYC);
      fastPh_next  = fastPh_reg ^ (fastCnt_reg == '0);
      slowPh_next  = slowPh_reg ^ (slowCnt_reg == '0);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fastCnt_reg <= '0;
      slowCnt_reg <= '0;
      fastPh_reg  <= 1'b0;
      slowPh_reg  <= 1'b0;
    end else begin
      fastCnt_reg <= fastCnt_next;
      slowCnt_reg <= slowCnt_next;
      fastPh_reg  <= fastPh_next;
      slowPh_reg  <= slowPh_next;
    end
  end

  // Sensing, register and pin drive
  always_comb begin
    state_next   = state_reg;
    polA_next    = polA_reg;
    polB_next    = polB_reg;
    duplex_next  = duplex_reg;
    ledCtrl_next = ledCtrl_reg;
    pinOut_next  = pinOut_reg;
    oeN_next     = oeN_reg;
    if (ce) begin
      if (regWrEn) begin
        ledCtrl_next = regWrData;
      end
      case (state_reg)
        ST_SENSE: begin
          // Pins released: an LED to supply pulls high, so the pin must sink
          polA_next   = !firstLedPinIn;
          polB_next   = !secondLedPinIn;
          duplex_next = secondLedPinIn;
          state_next  = ST_RUN;
        end
        ST_RUN: begin
          // Polarity is never resampled here
          oeN_next    = 1'b0;
          pinOut_next = {second_led_pin.ledOn ? polB_reg : !polB_reg,
                         first_led_pin.ledOn ? polA_reg : !polA_reg};
        end
        default: state_next = ST_SENSE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg   <= ST_SENSE;
      polA_reg    <= 1'b1;
      polB_reg    <= 1'b1;
      duplex_reg  <= 1'b0;
      ledCtrl_reg <= LED_CTRL_RESET;
      pinOut_reg  <= 2'h0;
      oeN_reg     <= 1'b1;
    end else begin
      state_reg   <= state_next;
      polA_reg    <= polA_next;
      polB_reg    <= polB_next;
      duplex_reg  <= duplex_next;
      ledCtrl_reg <= ledCtrl_next;
      pinOut_reg  <= pinOut_next;
      oeN_reg     <= oeN_next;
    end
  end

  // Only the management port reaches the register
  assign regRdData       = ledCtrl_reg;
  assign firstLedPinOut  = pinOut_reg[0];
  assign secondLedPinOut = pinOut_reg[1];
  assign firstLedPinOeN  = oeN_reg;
  assign secondLedPinOeN = oeN_reg;
  assign duplexSelectBit = duplex_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sense_released: assert property ($fell(rst) |-> firstLedPinOeN && secondLedPinOeN)
    else $error("pins driven during sensing");
  a_duplex_strap: assert property ((state_reg == ST_SENSE && ce)
      |=> duplexSelectBit == $past(secondLedPinIn))
    else $error("duplex strap not taken from second pin");
  a_polarity_hold: assert property ((state_reg == ST_RUN)
      |=> $stable(polA_reg) && $stable(polB_reg))
    else $error("polarity changed while running");
  a_run_drives: assert property ((state_reg == ST_SENSE && ce) ##1 ce
      |=> !firstLedPinOeN && !secondLedPinOeN)
    else $error("pins not driven after sensing");
  a_reset_value: assert property ($past(rst) |-> regRdData == LED_CTRL_RESET)
    else $error("wrong control register reset value");
  a_write_stores: assert property ((regWrEn && ce) |=> regRdData == $past(regWrData))
    else $error("register write lost");
  a_on_code: assert property ((state_reg == ST_RUN && ce && firstSel == FN_ON)
      |=> firstLedPinOut == polA_reg)
    else $error("on code does not light first LED");
  a_off_code: assert property ((state_reg == ST_RUN && ce && secondSel == FN_OFF)
      |=> secondLedPinOut == !polB_reg)
    else $error("off code does not darken second LED");
  a_link_show: assert property ((state_reg == ST_RUN && ce && firstSel == FN_LINK)
      |=> firstLedPinOut == ($past(linkUp) ? polA_reg : !polA_reg))
    else $error("link code does not follow link");
  a_live_activity: assert property ((state_reg == ST_RUN && ce &&
      firstSel == FN_TX && !strchEn) ##1 (ce && firstSel == FN_TX && !strchEn)
      |=> firstLedPinOut == ($past(txActive) ? polA_reg : !polA_reg))
    else $error("unstretched activity not shown live");

  c_full_duplex: cover property (state_reg == ST_SENSE && ce && secondLedPinIn);
  c_long_stretch: cover property (state_reg == ST_RUN && ledCtrl_reg[3:2] == STRETCH_LONG);
  c_combined: cover property (state_reg == ST_RUN && firstSel == FN_LINK_TXRX && txActive);

endmodule

`default_nettype wire

// *** core/pld_pkg.sv ***
// Constants shared by the LED driver control block.
// Assumes a 100 MHz core clock; all counts derive from it.
`default_nettype none

package pld_pkg;

  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  // Stretch lengths in ms and in cycles
  localparam int unsigned NORMAL_STRETCH_MS  = 40;
  localparam int unsigned MEDIUM_STRETCH_MS  = 70;
  localparam int unsigned LONG_STRETCH_MS    = 140;
  localparam int unsigned NORMAL_STRETCH_CYC = NORMAL_STRETCH_MS * CYC_PER_MS;
  localparam int unsigned MEDIUM_STRETCH_CYC = MEDIUM_STRETCH_MS * CYC_PER_MS;
  localparam int unsigned LONG_STRETCH_CYC   = LONG_STRETCH_MS * CYC_PER_MS;

  // Blink half periods in ms and in cycles
  localparam int unsigned BLINK_FAST_MS  = 100;
  localparam int unsigned BLINK_SLOW_MS  = 500;
  localparam int unsigned BLINK_FAST_CYC = BLINK_FAST_MS * CYC_PER_MS;
  localparam int unsigned BLINK_SLOW_CYC = BLINK_SLOW_MS * CYC_PER_MS;

  // LED control register layout
  localparam int unsigned FIRST_FN_LSB    = 8;
  localparam int unsigned SECOND_FN_LSB   = 4;
  localparam int unsigned STRETCH_SEL_LSB = 2;
  localparam int unsigned STRETCH_EN_BIT  = 1;
  localparam logic [15:0] LED_CTRL_RESET  = 16'h3422;

  // Function selector codes
  localparam logic [3:0] FN_TX        = 4'h1;
  localparam logic [3:0] FN_RX        = 4'h2;
  localparam logic [3:0] FN_COL       = 4'h3;
  localparam logic [3:0] FN_LINK      = 4'h4;
  localparam logic [3:0] FN_DUPLEX    = 4'h5;
  localparam logic [3:0] FN_TXRX      = 4'h7;
  localparam logic [3:0] FN_ON        = 4'h8;
  localparam logic [3:0] FN_OFF       = 4'h9;
  localparam logic [3:0] FN_FAST      = 4'hA;
  localparam logic [3:0] FN_SLOW      = 4'hB;
  localparam logic [3:0] FN_LINK_RX   = 4'hC;
  localparam logic [3:0] FN_LINK_TXRX = 4'hD;
  localparam logic [3:0] FN_DUP_COL   = 4'hE;

  // Stretch length codes
  localparam logic [1:0] STRETCH_NORMAL = 2'h0;
  localparam logic [1:0] STRETCH_MEDIUM = 2'h1;
  localparam logic [1:0] STRETCH_LONG   = 2'h2;

  typedef enum logic [1:0] {
    ST_SENSE = 2'b01,
    ST_RUN   = 2'b10
  } pld_state_e;

endpackage

`default_nettype wire

// *** core/pld_led_if.sv ***
// Carrier between the control top and one LED function unit.
// Assumes both ends share the same clock.
`timescale 1ns/1ps
`default_nettype none

interface pld_led_if #(
  parameter int unsigned CNT_W = 24
);
  logic [3:0]       sel;
  logic             txAct;
  logic             rxAct;
  logic             colAct;
  logic             link;
  logic             duplex;
  logic             blinkFast;
  logic             blinkSlow;
  logic             stretchEn;
  logic [CNT_W-1:0] stretchCycles;
  logic             ledOn;

  modport provider (output sel, txAct, rxAct, colAct, link, duplex, blinkFast,
                    blinkSlow, stretchEn, stretchCycles, input ledOn);
  modport user (input sel, txAct, rxAct, colAct, link, duplex, blinkFast,
                blinkSlow, stretchEn, stretchCycles, output ledOn);
endinterface

`default_nettype wire

// *** core/pld_led_func.sv ***
// One LED function unit: selector decode and pulse stretching.
// Assumes status inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module pld_led_func #(
  parameter int unsigned CNT_W = 24
) (
  // Clock and reset
  input wire logic     clk,
  input wire logic     rst,
  input wire logic     ce,
  // Link to control top
  pld_led_if.user      io
);
  import pld_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             actRaw;
  logic             base;
  logic             stretchable;
  logic             alwaysStretch;
  logic             doStretch;
  logic             act;

  always_comb begin
    actRaw        = 1'b0;
    base          = 1'b0;
    stretchable   = 1'b0;
    alwaysStretch = 1'b0;
    case (io.sel)
      FN_TX: begin
        actRaw      = io.txAct;
        stretchable = 1'b1;
      end
      FN_RX: begin
        actRaw      = io.rxAct;
        stretchable = 1'b1;
      end
      FN_COL: begin
        actRaw      = io.colAct;
        stretchable = 1'b1;
      end
      FN_TXRX: begin
        actRaw      = io.txAct | io.rxAct;
        stretchable = 1'b1;
      end
      FN_LINK:   base = io.link;
      FN_DUPLEX: base = io.duplex;
      FN_ON:     base = 1'b1;
      FN_OFF:    base = 1'b0;
      FN_FAST:   base = io.blinkFast;
      FN_SLOW:   base = io.blinkSlow;
      FN_LINK_RX: begin
        base          = io.link;
        actRaw        = io.rxAct;
        alwaysStretch = 1'b1;
      end
      FN_LINK_TXRX: begin
        base          = io.link;
        actRaw        = io.txAct | io.rxAct;
        alwaysStretch = 1'b1;
      end
      FN_DUP_COL: begin
        base          = io.duplex;
        actRaw        = io.colAct;
        alwaysStretch = 1'b1;
      end
      // Reserved codes keep the LED dark
      default: base = 1'b0;
    endcase
    // Combined codes stretch regardless of the enable bit
    doStretch = alwaysStretch | (stretchable & io.stretchEn);
    cnt_next  = cnt_reg;
    if (ce) begin
      if (!doStretch) begin
        cnt_next = '0;
      end else if (actRaw) begin
        cnt_next = io.stretchCycles;
      end else if (cnt_reg != '0) begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
    act      = actRaw | (doStretch & (cnt_reg != '0));
    // Activity inverts the status so it stays visible while linked
    io.ledOn = base ^ act;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

`default_nettype wire

// *** verification/pld_led_lamps.sv ***
// Model of the two lamps wired to the LED driver pins.
// Assumes active low output enables; a released pin is pulled by its lamp.
`timescale 1ns/1ps
`default_nettype none

module pld_led_lamps (
  // Lamp wiring, 1 = lamp to supply so the pin sinks
  input  wire logic aSink,
  input  wire logic bSink,
  // Pin drive from the device
  input  wire logic aOut,
  input  wire logic aOeN,
  input  wire logic bOut,
  input  wire logic bOeN,
  // Pin level read back and lamp state
  output logic      aIn,
  output logic      bIn,
  output logic      aLit,
  output logic      bLit
);
  // Released pin follows the lamp's far end: supply or ground
  assign aIn  = aOeN ? aSink : aOut;
  assign bIn  = bOeN ? bSink : bOut;
  assign aLit = !aOeN && (aOut ^ aSink);
  assign bLit = !bOeN && (bOut ^ bSink);
endmodule

`default_nettype wire

// *** verification/tb_pld_led_control.sv ***
// Self-checking bench for the LED driver control block.
// Assumes shortened stretch and blink counts; lamps from pld_led_lamps.
`timescale 1ns/1ps
`default_nettype none

module tb_pld_led_control;
  import pld_pkg::*;
  localparam int unsigned NCYC = 20;
  localparam int unsigned MCYC = 35;
  localparam int unsigned LCYC = 70;
  localparam int unsigned FCYC = 8;
  localparam int unsigned SCYC = 16;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        regWrEn = 1'b0;
  logic [15:0] regWrData = 16'h0000;
  logic [15:0] regRdData;
  logic        linkUp = 1'b0, duplexFull = 1'b0;
  logic        txActive = 1'b0, rxActive = 1'b0, colActive = 1'b0;
  logic        aSink = 1'b0, bSink = 1'b1;
  logic        aIn, aOut, aOeN, bIn, bOut, bOeN, dupSel, aLit, bLit;
  int          failures = 0;
  int          checkCount = 0;
  logic [3:0]  codes [8] = '{FN_ON, FN_OFF, FN_LINK, FN_DUPLEX, FN_TX, FN_RX, FN_COL, FN_TXRX};
  // Status sources that light each code: {col, rx, tx, duplex, link}
  logic [4:0]  masks [8] = '{5'h1F, 5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h0C};

  always #5 clk = ~clk;

  pld_led_control #(.NORMAL_CYC(NCYC), .MEDIUM_CYC(MCYC), .LONG_CYC(LCYC),
                    .FAST_CYC(FCYC), .SLOW_CYC(SCYC)) pld_led_control_i (
    .clk(clk), .rst(rst), .ce(ce), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdData(regRdData), .linkUp(linkUp), .duplexFull(duplexFull),
    .txActive(txActive), .rxActive(rxActive), .colActive(colActive),
    .firstLedPinIn(aIn), .firstLedPinOut(aOut), .firstLedPinOeN(aOeN),
    .secondLedPinIn(bIn), .secondLedPinOut(bOut), .secondLedPinOeN(bOeN),
    .duplexSelectBit(dupSel));

  pld_led_lamps pld_led_lamps_i (
    .aSink(aSink), .bSink(bSink), .aOut(aOut), .aOeN(aOeN), .bOut(bOut), .bOeN(bOeN),
    .aIn(aIn), .bIn(bIn), .aLit(aLit), .bLit(bLit));

  task automatic close_out;
    if (failures == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset(input logic sa, input logic sb);
    aSink = sa;
    bSink = sb;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // One write, then two edges so the pins reflect it
  task automatic ctl(input logic [3:0] fa, input logic [3:0] fb, input logic [1:0] sel,
                     input logic en);
    regWrEn = 1'b1;
    regWrData = {4'h3, fa, fb, sel, en, 1'b0};
    @(posedge clk);
    #1 regWrEn = 1'b0;
    check(regRdData, regWrData);
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Cycles between two successive lamp changes
  task automatic half(input logic useB, input int exp);
    logic v;
    int   n;
    for (int k = 0; k < 2; k++) begin
      v = useB ? bLit : aLit;
      n = 0;
      while ((useB ? bLit : aLit) === v && n < 200) begin
        @(posedge clk);
        #1 n++;
      end
    end
    check(16'(n), 16'(exp));
  endtask

  // One-cycle activity pulse; count cycles the lamp differs from its base level
  task automatic stretch(input logic [3:0] fn, input logic [1:0] sel, input logic en,
                         input int lo, input int hi, input logic base);
    int n;
    ctl(fn, FN_OFF, sel, en);
    {colActive, rxActive, txActive} = 3'b111;
    @(posedge clk);
    #1 {colActive, rxActive, txActive} = 3'b000;
    // The pulse cycle itself already shows on the lamp
    n = (aLit !== base) ? 1 : 0;
    repeat (LCYC + 20) begin
      @(posedge clk);
      #1 if (aLit !== base) n++;
    end
    check(16'(n >= lo && n <= hi), 16'h0001);
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    close_out();
  end

  initial begin
    do_reset(1'b0, 1'b1);
    check(regRdData, 16'h3422);
    check(16'(dupSel), 16'h0001);
    check(16'({aOeN, bOeN}), 16'h0000);
    check(16'({aLit, bLit}), 16'h0000);
    linkUp = 1'b1;
    repeat (3) @(posedge clk);
    #1 check(16'({aLit, bLit}), 16'h0002);
    // A write while the clock enable is low must not land
    ce = 1'b0;
    regWrEn = 1'b1;
    regWrData = 16'h3990;
    @(posedge clk);
    #1 regWrEn = 1'b0;
    ce = 1'b1;
    check(regRdData, 16'h3422);
    for (int j = 0; j < 5; j++) begin
      {colActive, rxActive, txActive, duplexFull, linkUp} = 5'(1 << j);
      for (int i = 0; i < 8; i++) begin
        ctl(codes[i], codes[(i + 3) % 8], STRETCH_NORMAL, 1'b0);
        check(16'(aLit), 16'(masks[i][j]));
        check(16'(bLit), 16'(masks[(i + 3) % 8][j]));
      end
    end
    {colActive, rxActive, txActive, duplexFull, linkUp} = 5'h00;
    ctl(FN_FAST, FN_SLOW, STRETCH_NORMAL, 1'b0);
    half(1'b0, FCYC);
    half(1'b1, SCYC);
    stretch(FN_RX, STRETCH_NORMAL, 1'b1, NCYC - 1, NCYC + 2, 1'b0);
    stretch(FN_TXRX, STRETCH_MEDIUM, 1'b1, MCYC - 1, MCYC + 2, 1'b0);
    stretch(FN_RX, STRETCH_LONG, 1'b1, LCYC - 1, LCYC + 2, 1'b0);
    stretch(FN_RX, STRETCH_LONG, 1'b0, 1, 2, 1'b0);
    stretch(FN_LINK_TXRX, STRETCH_NORMAL, 1'b0, NCYC - 1, NCYC + 2, 1'b0);
    linkUp = 1'b1;
    stretch(FN_LINK_RX, STRETCH_MEDIUM, 1'b0, MCYC - 1, MCYC + 2, 1'b1);
    stretch(FN_DUP_COL, STRETCH_LONG, 1'b0, LCYC - 1, LCYC + 2, 1'b0);
    ctl(FN_ON, FN_OFF, STRETCH_NORMAL, 1'b0);
    check(16'(aOut), 16'h0001);
    // Rewire the first lamp while running; drive sense must not follow
    aSink = 1'b1;
    repeat (3) @(posedge clk);
    #1 check(16'(aOut), 16'h0001);
    do_reset(1'b1, 1'b0);
    check(16'(dupSel), 16'h0000);
    check(regRdData, 16'h3422);
    ctl(FN_ON, FN_ON, STRETCH_NORMAL, 1'b0);
    check(16'({aOut, bOut}), 16'h0001);
    check(16'({aLit, bLit}), 16'h0003);
    close_out();
  end
endmodule

`default_nettype wire
